// File: tb/tb.sv
// testbench for the orientation detect block: apb access, results,
// debounce, sleep restart, masking, high-g hold and disable
// assumes: ori_pkg and ori_detect_regs compiled first, one 100 MHz clock
`timescale 1ns/10ps

module tb;
	localparam int BASE = 20;

	// ==========================================
	// signals
	logic               sys_clk;
	logic               resetn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [3:0]         pstrb;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               active;
	logic               sleep_mode;
	logic [2:0]         output_sample_rate;
	logic [1:0]         oversample_mode;
	logic               sample_valid;
	logic signed [13:0] accel_x;
	logic signed [13:0] accel_y;
	logic signed [13:0] accel_z;
	logic [8:0]         z_angle_deg;
	logic [8:0]         z_tilt_deg;
	logic [1:0]         landscape_portrait_raw;
	logic               irq;
	int                 n_mismatch;
	int                 comparisons;

	// ==========================================
	// design under test, short step for simulation
	ori_detect_regs #(.STEP_BASE_CYCLES(BASE)) dut_u (
		.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .active(active),
		.sleep_mode(sleep_mode), .output_sample_rate(output_sample_rate),
		.oversample_mode(oversample_mode), .sample_valid(sample_valid),
		.accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
		.z_angle_deg(z_angle_deg), .z_tilt_deg(z_tilt_deg),
		.landscape_portrait_raw(landscape_portrait_raw), .irq(irq));

	// clock, 10 ns period
	always #5 sys_clk = ~sys_clk;

	// ==========================================
	// reporting
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// compare one value
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// ==========================================
	// apb master: setup, access held until pready
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// register write
	task automatic wr(input logic [7:0] addr, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, addr, {24'h00_0000, d}, r, e);
	endtask

	// register read with expected data and error
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b0, addr, 32'h0000_0000, r, e);
		check(r, {24'h00_0000, exp}, "read data");
		check({31'h0, e}, {31'h0, exp_err}, "slave error");
	endtask

	// one sample pulse with its qualifiers
	task automatic feed(input logic [1:0] lp, input logic [8:0] za, input logic [8:0] zt,
			input logic signed [13:0] ax);
		@(posedge sys_clk);
		landscape_portrait_raw <= lp;
		z_angle_deg <= za;
		z_tilt_deg <= zt;
		accel_x <= ax;
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
	endtask

	// wait up to lim cycles for irq, then compare its level
	task automatic wait_irq(input int lim, input logic exp);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(posedge sys_clk);
			k++;
		end
		check({31'h0, irq}, {31'h0, exp}, "irq level");
	endtask

	// ==========================================
	// scenarios
	task automatic s_reset();
		rd(8'h40, 8'h00, 1'b0);
		rd(8'h44, 8'h80, 1'b0);
		rd(8'h48, 8'h00, 1'b0);
		rd(8'h4C, 8'h44, 1'b0);
		rd(8'h54, 8'h00, 1'b0);
		rd(8'h7C, 8'h00, 1'b1);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00, 1'b0);
		wr(8'h48, 8'hA5);
		rd(8'h48, 8'hA5, 1'b0);
		pstrb <= 4'hE;
		wr(8'h48, 8'h00);
		rd(8'h48, 8'hA5, 1'b0);
		pstrb <= 4'hF;
		wr(8'h48, 8'h00);
	endtask

	// first result after standby sets the flag, masked irq stays low
	task automatic s_first();
		wr(8'h44, 8'hC0);
		@(posedge sys_clk);
		active <= 1'b1;
		feed(2'b00, 9'd0, 9'd0, 14'sd0);
		wait_irq(100, 1'b0);
		rd(8'h50, 8'h01, 1'b0);
		rd(8'h50, 8'h00, 1'b0);
		rd(8'h40, 8'h80, 1'b0);
		rd(8'h40, 8'h00, 1'b0);
		wr(8'h54, 8'h01);
	endtask

	// every code, back and lockout, tracking while flag set
	task automatic s_codes();
		for (int i = 1; i < 4; i++) begin
			feed(2'(i), 9'd0, 9'd0, 14'sd0);
			wait_irq(60, 1'b1);
			rd(8'h40, 8'h80 | 8'(i << 1), 1'b0);
			@(posedge sys_clk);
			check({31'h0, irq}, 32'h0, "irq after read");
		end
		feed(2'b00, 9'd180, 9'd40, 14'sd0);
		repeat (60) @(posedge sys_clk);
		feed(2'b11, 9'd180, 9'd40, 14'sd0);
		repeat (60) @(posedge sys_clk);
		rd(8'h40, 8'hC7, 1'b0);
		wr(8'h4C, 8'h47);
		feed(2'b11, 9'd180, 9'd40, 14'sd0);
		wait_irq(60, 1'b1);
		rd(8'h40, 8'h87, 1'b0);
	endtask

	// above 1.25 g the result holds, at exactly 1.25 g it moves
	task automatic s_highg();
		feed(2'b00, 9'd0, 9'd0, 14'sd6000);
		wait_irq(100, 1'b0);
		rd(8'h40, 8'h07, 1'b0);
		feed(2'b00, 9'd0, 9'd0, 14'sd5120);
		wait_irq(60, 1'b1);
		rd(8'h40, 8'h80, 1'b0);
		rd(8'h50, 8'h02, 1'b0);
	endtask

	// debounce count, sleep restart, slower step
	task automatic s_debounce();
		wr(8'h48, 8'h03);
		feed(2'b01, 9'd0, 9'd0, 14'sd0);
		wait_irq(30, 1'b0);
		wait_irq(150, 1'b1);
		rd(8'h40, 8'h82, 1'b0);
		feed(2'b10, 9'd0, 9'd0, 14'sd0);
		repeat (45) @(posedge sys_clk);
		sleep_mode <= 1'b1;
		wait_irq(50, 1'b0);
		wait_irq(150, 1'b1);
		rd(8'h40, 8'h84, 1'b0);
		oversample_mode <= 2'd2;
		output_sample_rate <= 3'd3;
		feed(2'b11, 9'd0, 9'd0, 14'sd0);
		wait_irq(70, 1'b0);
		wait_irq(200, 1'b1);
		rd(8'h40, 8'h86, 1'b0);
	endtask

	// detection off: samples ignored
	task automatic s_disable();
		wr(8'h44, 8'h80);
		feed(2'b00, 9'd0, 9'd0, 14'sd0);
		wait_irq(200, 1'b0);
		rd(8'h40, 8'h06, 1'b0);
	endtask

	// decrement mode: a cancelled change never commits; back trip at 80 degrees
	task automatic s_decrement();
		wr(8'h44, 8'h40);
		oversample_mode <= 2'd0;
		output_sample_rate <= 3'd0;
		feed(2'b01, 9'd0, 9'd0, 14'sd0);
		repeat (50) @(posedge sys_clk);
		feed(2'b11, 9'd0, 9'd0, 14'sd0);
		wait_irq(150, 1'b0);
		rd(8'h40, 8'h06, 1'b0);
		wr(8'h4C, 8'h04);
		feed(2'b11, 9'd103, 9'd0, 14'sd0);
		wait_irq(150, 1'b1);
		rd(8'h40, 8'h87, 1'b0);
	endtask

	// ==========================================
	// main sequence
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		active = 1'b0;
		sleep_mode = 1'b0;
		output_sample_rate = 3'd0;
		oversample_mode = 2'd0;
		sample_valid = 1'b0;
		accel_x = 14'sd0;
		accel_y = 14'sd0;
		accel_z = 14'sd0;
		z_angle_deg = 9'd0;
		z_tilt_deg = 9'd0;
		landscape_portrait_raw = 2'b00;
		n_mismatch = 0;
		comparisons = 0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		s_reset();
		s_first();
		s_codes();
		s_highg();
		s_debounce();
		s_disable();
		s_decrement();
		give_verdict();
	end

	// hang guard
	initial begin
		repeat (50000) @(posedge sys_clk);
		n_mismatch++;
		give_verdict();
	end
endmodule

// File: verilog/ori_defs.svh
// orientation detect constants: register indices, field positions,
// reset values and timing figures
// assumes: included by the design modules by bare name; the package does not include it
`ifndef ORI_DEFS_SVH
`define ORI_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define ORI_IDX_STATUS     6'h10
`define ORI_IDX_CONFIG     6'h11
`define ORI_IDX_COUNT      6'h12
`define ORI_IDX_THRESH     6'h13
`define ORI_IDX_IRQ_STAT   6'h14
`define ORI_IDX_IRQ_MASK   6'h15

// ==========================================================
// field positions
`define ORI_STAT_CHANGE    7
`define ORI_STAT_LOCK      6
`define ORI_STAT_LP_HI     2
`define ORI_STAT_LP_LO     1
`define ORI_STAT_BF        0
`define ORI_CFG_MODE       7
`define ORI_CFG_EN         6
`define ORI_THR_BF_HI      7
`define ORI_THR_BF_LO      6
`define ORI_THR_ZL_HI      2
`define ORI_THR_ZL_LO      0
`define ORI_IRQ_CHANGE     0
`define ORI_IRQ_HIGH_G     1

// ==========================================================
// reset values
`define ORI_CFG_RESET      8'h80
`define ORI_COUNT_RESET    8'h00
`define ORI_THR_RESET      8'h44
`define ORI_MASK_RESET     2'h0

// ==========================================================
// timing and scale
`define ORI_CLK_PERIOD_PS  10000
`define ORI_STEP_BASE_PS   1250000000
`define ORI_STEP_BASE_CYC  (`ORI_STEP_BASE_PS / `ORI_CLK_PERIOD_PS)
`define ORI_HOLD_MILLI_G   1250
`define ORI_G_COUNTS       4096

`endif

// File: verilog/ori_detect_regs.sv
// orientation detect: classification, debounce, status and APB registers
// assumes: axis samples and angles arrive from the sample datapath with
// a one-cycle sample_valid pulse, synchronous to sys_clk
`timescale 1ns/10ps
`include "ori_defs.svh"

module ori_detect_regs import ori_pkg::*; #(
	parameter int STEP_BASE_CYCLES = `ORI_STEP_BASE_CYC,
	parameter int G_COUNTS         = `ORI_G_COUNTS
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// operating state
	input  wire logic               active,
	input  wire logic               sleep_mode,
	input  wire logic [2:0]         output_sample_rate,
	input  wire logic [1:0]         oversample_mode,
	// sample datapath
	input  wire logic               sample_valid,
	input  wire logic signed [13:0] accel_x,
	input  wire logic signed [13:0] accel_y,
	input  wire logic signed [13:0] accel_z,
	input  wire logic [8:0]         z_angle_deg,
	input  wire logic [8:0]         z_tilt_deg,
	input  wire logic [1:0]         landscape_portrait_raw,
	// interrupt
	output logic                    irq
);
	localparam logic [13:0] HOLD_LIMIT = 14'(G_COUNTS * `ORI_HOLD_MILLI_G / 1000);

	// ==========================================================
	// register state
	logic       orientation_change_flag;
	logic       tilt_lockout_flag;
	logic [1:0] landscape_portrait_code;
	logic       back_front_flag;
	logic       debounce_mode_select;
	logic       orientation_detect_enable;
	logic [7:0] debounce_count_value;
	logic [1:0] back_front_trip_select;
	logic [2:0] tilt_lockout_angle_select;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;

	// ==========================================================
	// detection state
	logic [3:0] cand;
	logic       cand_valid;
	logic [7:0] dbc;
	logic       first_pending;
	logic       active_q;
	logic       sleep_q;
	logic       high_g_q;

	// ==========================================================
	// apb decode
	wire [5:0] idx       = paddr[7:2];
	wire       sel_stat  = (idx == `ORI_IDX_STATUS);
	wire       sel_cfg   = (idx == `ORI_IDX_CONFIG);
	wire       sel_cnt   = (idx == `ORI_IDX_COUNT);
	wire       sel_thr   = (idx == `ORI_IDX_THRESH);
	wire       sel_istat = (idx == `ORI_IDX_IRQ_STAT);
	wire       sel_imask = (idx == `ORI_IDX_IRQ_MASK);
	wire       mapped    = sel_stat | sel_cfg | sel_cnt | sel_thr | sel_istat | sel_imask;
	wire       acc_wait  = psel && penable && !pready;
	wire       acc_done  = psel && penable && pready;
	wire       wr_lane   = acc_done && pwrite && pstrb[0];
	wire       rd_stat   = acc_done && !pwrite && sel_stat;
	wire       rd_istat  = acc_done && !pwrite && sel_istat;

	// read data selection
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h0000_0000;
		if (sel_stat) begin
			rdata[7:0] = {orientation_change_flag, tilt_lockout_flag, 3'h0,
				landscape_portrait_code, back_front_flag};
		end else if (sel_cfg) begin
			rdata[7:0] = {debounce_mode_select, orientation_detect_enable, 6'h00};
		end else if (sel_cnt) begin
			rdata[7:0] = debounce_count_value;
		end else if (sel_thr) begin
			rdata[7:0] = {back_front_trip_select, 3'h0, tilt_lockout_angle_select};
		end else if (sel_istat) begin
			rdata[1:0] = irq_status;
		end else if (sel_imask) begin
			rdata[1:0] = irq_mask;
		end
	end

	// apb answer: one wait cycle, then pready with registered data
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc_wait;
			pslverr <= acc_wait && !mapped;
			if (acc_wait) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata;
			end
		end
	end

	// writable registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			debounce_mode_select      <= 1'(`ORI_CFG_RESET >> `ORI_CFG_MODE);
			orientation_detect_enable <= 1'b0;
			debounce_count_value      <= `ORI_COUNT_RESET;
			back_front_trip_select    <= 2'(`ORI_THR_RESET >> `ORI_THR_BF_LO);
			tilt_lockout_angle_select <= 3'(`ORI_THR_RESET);
			irq_mask                  <= `ORI_MASK_RESET;
		end else if (wr_lane) begin
			if (sel_cfg) begin
				debounce_mode_select      <= pwdata[`ORI_CFG_MODE];
				orientation_detect_enable <= pwdata[`ORI_CFG_EN];
			end
			if (sel_cnt) begin
				debounce_count_value <= pwdata[7:0];
			end
			if (sel_thr) begin
				back_front_trip_select    <= pwdata[`ORI_THR_BF_HI:`ORI_THR_BF_LO];
				tilt_lockout_angle_select <= pwdata[`ORI_THR_ZL_HI:`ORI_THR_ZL_LO];
			end
			if (sel_imask) begin
				irq_mask <= pwdata[1:0];
			end
		end
	end

	// ==========================================================
	// time step generator
	wire       run       = orientation_detect_enable && active;
	wire       sleep_chg = (sleep_mode != sleep_q);
	wire       restart   = !run || sleep_chg;
	wire [2:0] shift     = ori_step_shift(ori_rate_t'(output_sample_rate),
		ori_os_t'(oversample_mode));
	logic      step_tick;

	ori_step_timer #(
		.BASE_CYCLES (STEP_BASE_CYCLES)
	) u_step (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.restart   (restart),
		.shift     (shift),
		.step_tick (step_tick)
	);

	// ==========================================================
	// raw classification of one sample
	wire       high_g   = (ori_abs(accel_x) > HOLD_LIMIT) || (ori_abs(accel_y) > HOLD_LIMIT)
		|| (ori_abs(accel_z) > HOLD_LIMIT);
	wire [8:0] bf_deg   = ori_bf_deg(back_front_trip_select);
	wire       to_front = (z_angle_deg < bf_deg) || (z_angle_deg > 9'(9'd360 - bf_deg));
	wire       to_back  = (z_angle_deg > 9'(9'd180 - bf_deg))
		&& (z_angle_deg < 9'(9'd180 + bf_deg));
	// back/front with hysteresis between the two trip regions
	wire       raw_bf   = to_front ? 1'b0 : (to_back ? 1'b1 : cand[0]);
	wire       raw_lock = (z_tilt_deg > ori_tilt_lockout_angle_select_deg(tilt_lockout_angle_select));
	wire [3:0] raw_res  = {raw_lock, landscape_portrait_raw, raw_bf};
	wire       take     = sample_valid && run && !high_g;

	// ==========================================================
	// debounce decisions
	wire [3:0] cur     = {tilt_lockout_flag, landscape_portrait_code, back_front_flag};
	wire       differs = (cand != cur) || first_pending;
	wire       eval    = step_tick && run && cand_valid && !sleep_chg;
	wire       commit  = eval && differs && (dbc >= debounce_count_value);

	// latest accepted sample
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cand       <= 4'h0;
			cand_valid <= 1'b0;
		end else if (take) begin
			cand       <= raw_res;
			cand_valid <= 1'b1;
		end else if (!run) begin
			cand_valid <= 1'b0;
		end
	end

	// debounce counter
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dbc <= 8'h00;
		end else if (restart) begin
			dbc <= 8'h00;
		end else if (eval) begin
			if (differs) begin
				dbc <= commit ? 8'h00 : dbc + 8'h01;
			end else if (debounce_mode_select || dbc == 8'h00) begin
				dbc <= 8'h00;
			end else begin
				dbc <= dbc - 8'h01;
			end
		end
	end

	// previous levels and first-result tracking
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			active_q      <= 1'b0;
			sleep_q       <= 1'b0;
			high_g_q      <= 1'b0;
			first_pending <= 1'b0;
		end else begin
			active_q <= active;
			sleep_q  <= sleep_mode;
			high_g_q <= high_g;
			if (active && !active_q) begin
				first_pending <= 1'b1;
			end else if (commit) begin
				first_pending <= 1'b0;
			end
		end
	end

	// ==========================================================
	// status fields and change flag; set wins over read clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			orientation_change_flag <= 1'b0;
			tilt_lockout_flag       <= 1'b0;
			landscape_portrait_code <= 2'h0;
			back_front_flag         <= 1'b0;
		end else begin
			if (commit) begin
				{tilt_lockout_flag, landscape_portrait_code, back_front_flag} <= cand;
			end
			orientation_change_flag <= commit || (orientation_change_flag && !rd_stat);
		end
	end

	// ==========================================================
	// interrupt status, mask and output
	logic [1:0] next_irq_status;
	always_comb begin
		next_irq_status = irq_status;
		if (rd_istat) begin
			next_irq_status = 2'h0;
		end
		if (rd_stat) begin
			next_irq_status[`ORI_IRQ_CHANGE] = 1'b0;
		end
		if (commit) begin
			next_irq_status[`ORI_IRQ_CHANGE] = 1'b1;
		end
		if (high_g && !high_g_q && run) begin
			next_irq_status[`ORI_IRQ_HIGH_G] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_status <= 2'h0;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	property p_flag_on_commit;
		commit |=> orientation_change_flag && irq_status[`ORI_IRQ_CHANGE];
	endproperty
	a_flag_on_commit: assert property (p_flag_on_commit) else $error("change flag missed");

	property p_read_clears;
		rd_stat && !commit |=> !orientation_change_flag && !irq_status[`ORI_IRQ_CHANGE];
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

	property p_tracks_while_set;
		commit && orientation_change_flag |=> cur == $past(cand);
	endproperty
	a_tracks_while_set: assert property (p_tracks_while_set) else $error("fields frozen");

	property p_high_g_hold;
		sample_valid && high_g |=> cand == $past(cand);
	endproperty
	a_high_g_hold: assert property (p_high_g_hold) else $error("result moved above limit");

	property p_disabled_idle;
		!run |-> !commit;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("commit while disabled");

	property p_clear_mode;
		eval && !differs && debounce_mode_select |=> dbc == 8'h00;
	endproperty
	a_clear_mode: assert property (p_clear_mode) else $error("counter not cleared");

	property p_dec_mode;
		eval && !differs && !debounce_mode_select && dbc != 8'h00 && !restart
			|=> dbc == $past(dbc) - 8'h01;
	endproperty
	a_dec_mode: assert property (p_dec_mode) else $error("counter not decremented");

	property p_count_gate;
		eval && differs && dbc < debounce_count_value
			|=> dbc == $past(dbc) + 8'h01 && !$rose(orientation_change_flag);
	endproperty
	a_count_gate: assert property (p_count_gate) else $error("change taken early");

	property p_persist;
		commit |-> dbc >= debounce_count_value && step_tick;
	endproperty
	a_persist: assert property (p_persist) else $error("commit before count");

	property p_sleep_reset;
		sleep_chg |=> dbc == 8'h00;
	endproperty
	a_sleep_reset: assert property (p_sleep_reset) else $error("sleep change kept counter");

	property p_apb_answer;
		s_setup ##1 s_access |-> !pready ##1 pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");
endmodule

// File: verilog/ori_pkg.sv
// orientation detect types and shared decode functions
// assumes: compiled before every design module
package ori_pkg;

	// oversampling modes
	typedef enum logic [1:0] {
		ORI_OS_NORMAL,
		ORI_OS_LNLP,
		ORI_OS_HIRES,
		ORI_OS_LP
	} ori_os_t;

	// sample rates, fastest first
	typedef enum logic [2:0] {
		ORI_RATE_800,
		ORI_RATE_400,
		ORI_RATE_200,
		ORI_RATE_100,
		ORI_RATE_50,
		ORI_RATE_12P5,
		ORI_RATE_6P25,
		ORI_RATE_1P56
	} ori_rate_t;

	// time step as power-of-two multiple of the 1.25 ms base
	function automatic logic [2:0] ori_step_shift(input ori_rate_t rate, input ori_os_t os);
		logic [2:0] s;
		s = 3'h0;
		if (rate == ORI_RATE_800) begin
			s = 3'h0;
		end else if (rate == ORI_RATE_400 || os == ORI_OS_HIRES) begin
			s = 3'h1;
		end else if (rate <= ORI_RATE_50) begin
			s = 3'(rate);
		end else if (os == ORI_OS_NORMAL) begin
			s = 3'h4;
		end else if (os == ORI_OS_LP && rate != ORI_RATE_12P5) begin
			s = 3'h7;
		end else begin
			s = 3'h6;
		end
		return s;
	endfunction

	// lockout trip angle in degrees
	function automatic logic [8:0] ori_tilt_lockout_angle_select_deg(input logic [2:0] sel);
		logic [8:0] d;
		case (sel)
			3'h0: d = 9'd14;
			3'h1: d = 9'd18;
			3'h2: d = 9'd21;
			3'h3: d = 9'd25;
			3'h4: d = 9'd29;
			3'h5: d = 9'd33;
			3'h6: d = 9'd37;
			default: d = 9'd42;
		endcase
		return d;
	endfunction

	// back/front trip angle in degrees
	function automatic logic [8:0] ori_bf_deg(input logic [1:0] sel);
		logic [8:0] d;
		case (sel)
			2'h0: d = 9'd80;
			2'h1: d = 9'd75;
			2'h2: d = 9'd70;
			default: d = 9'd65;
		endcase
		return d;
	endfunction

	// magnitude of a signed axis sample
	function automatic logic [13:0] ori_abs(input logic signed [13:0] v);
		return v[13] ? 14'(-v) : 14'(v);
	endfunction

endpackage

// File: verilog/ori_step_timer.sv
// debounce time step generator
// assumes: one 100 MHz clock; restart is a level, counters stay cleared while it is high
`timescale 1ns/10ps
`include "ori_defs.svh"

module ori_step_timer import ori_pkg::*; #(
	parameter int BASE_CYCLES = `ORI_STEP_BASE_CYC
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// control
	input  wire logic       restart,
	input  wire logic [2:0] shift,
	// step pulse
	output logic            step_tick
);
	localparam int BW = $clog2(BASE_CYCLES + 1);

	logic [BW-1:0] base_cnt;
	logic [6:0]    pre_cnt;

	// ==========================================================
	// base tick every 1.25 ms, then power-of-two prescale
	wire       base_end  = (base_cnt == BW'(BASE_CYCLES - 1));
	wire [6:0] pre_limit = 7'((8'h01 << shift) - 8'h01);
	wire       pre_end   = (pre_cnt >= pre_limit);

	// counters
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			base_cnt  <= '0;
			pre_cnt   <= '0;
			step_tick <= 1'b0;
		end else if (restart) begin
			base_cnt  <= '0;
			pre_cnt   <= '0;
			step_tick <= 1'b0;
		end else begin
			base_cnt  <= base_end ? '0 : base_cnt + 1'b1;
			if (base_end) begin
				pre_cnt <= pre_end ? 7'h00 : pre_cnt + 7'h01;
			end
			step_tick <= base_end && pre_end;
		end
	end
endmodule
